//--- hdl/adcs_map.vh
`ifndef ADCS_MAP_VH
`define ADCS_MAP_VH

// ==========================================================================
// register offsets (3-bit word address)
// ==========================================================================
`define ADCS_OFF_CTRL      3'h0
`define ADCS_OFF_CLKSEL    3'h1
`define ADCS_OFF_RES_LO    3'h2
`define ADCS_OFF_RES_HI    3'h3
`define ADCS_OFF_IRQ_STAT  3'h4
`define ADCS_OFF_IRQ_MASK  3'h5

// ==========================================================================
// conv_control_reg fields
// ==========================================================================
`define ADCS_CTRL_START    7
`define ADCS_CTRL_PEND     6
`define ADCS_CTRL_PIN_HI   5
`define ADCS_CTRL_PIN_LO   3
`define ADCS_CTRL_CH_HI    2
`define ADCS_CTRL_CH_LO    0

// ==========================================================================
// conv_clock_select_reg and irq register fields
// ==========================================================================
`define ADCS_CLK_SEL_HI    1
`define ADCS_CLK_SEL_LO    0
`define ADCS_IRQ_DONE      0
`define ADCS_MASK_GIE      7
`define ADCS_RES_LO_D0     7

// ==========================================================================
// reset values
// ==========================================================================
`define ADCS_RST_PIN_SEL   3'h0
`define ADCS_RST_CHAN      3'h0
`define ADCS_RST_CLK_SEL   2'h0
`define ADCS_RST_PEND      1'b1
`define ADCS_RST_RES       8'h00

// ==========================================================================
// divider terminal counts and conversion lengths
// ==========================================================================
`define ADCS_DIV2_TERM     5'h01
`define ADCS_DIV8_TERM     5'h07
`define ADCS_DIV32_TERM    5'h1F
`define ADCS_CLKSEL_DIV2   2'h0
`define ADCS_CLKSEL_DIV8   2'h1
`define ADCS_CLKSEL_DIV32  2'h2
`define ADCS_LEN_8BIT      7'd64
`define ADCS_LEN_9BIT      7'd76

`endif

//--- hdl/adcs_clk_div.v
`include "adcs_map.vh"

// converter clock divider: one tick per converter clock period
module adcs_clk_div (
  // clock and reset
  input  wire       clk_i,
  input  wire       rst_n_i,
  // control
  input  wire [1:0] sel_i,
  input  wire       clr_i,
  // converter clock
  output wire       tick_o,
  output wire       conv_clk_o
);

  reg  [4:0] cnt_q;
  reg  [4:0] cnt_d;
  reg        clk_q;
  reg        clk_d;
  reg  [4:0] term;

  // ========================================================================
  // ratio decode
  // ========================================================================
  always @* begin
    case (sel_i)
      `ADCS_CLKSEL_DIV2:  term = `ADCS_DIV2_TERM;
      `ADCS_CLKSEL_DIV8:  term = `ADCS_DIV8_TERM;
      `ADCS_CLKSEL_DIV32: term = `ADCS_DIV32_TERM;
      // undefined code runs at the slowest ratio
      default:            term = `ADCS_DIV32_TERM;
    endcase
  end

  assign tick_o = (cnt_q == term) && !clr_i;

  always @* begin
    cnt_d = cnt_q + 5'h01;
    clk_d = clk_q;
    if (clr_i) begin
      cnt_d = 5'h00;
      clk_d = 1'b0;
    end else if (cnt_q == term) begin
      cnt_d = 5'h00;
      clk_d = 1'b0;
    end else if (cnt_q == (term >> 1)) begin
      clk_d = 1'b1;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 5'h00;
      clk_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      clk_q <= clk_d;
    end
  end

  assign conv_clk_o = clk_q;

endmodule // adcs_clk_div

//--- hdl/adcs_sequencer.v
`include "adcs_map.vh"

// Functional notes
// - without that pulse the pending flag keeps a stale, meaningless value
// - the start pulse leaves the pending flag reliably high
// - pending flag falls at completion; result registers then hold the value
// - completion interrupt needs both enables and a stack that is not full
// - converter clock is system clock divided by 2, 8 or 32
// - a conversion lasts 64 converter clocks, or 76 for nine bits
// - conversion runs on its own; seen only via flag and interrupt
// - zero pin selection: no analog pins, converter powered off
// - writing 01h to clock select gives system clock divided by eight
// - converter setup comes from registers, except resolution, which parameter RES9 fixes
// - start held high keeps the converter in reset, flag at one
// - pin selection of 100b or more makes all four pins analog
// - nine-bit result: high register bits 8..1, low register bit 7 bit 0
module adcs_sequencer #(
  parameter RES9 = 1
) (
  // clock and reset
  input  wire       clk_i,
  input  wire       rst_n_i,
  // register port
  input  wire [2:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       we_i,
  input  wire       re_i,
  output wire [7:0] rdata_o,
  // converter core
  input  wire [8:0] conv_data_i,
  output wire [2:0] channel_o,
  output wire       conv_power_o,
  output wire       conv_reset_o,
  output wire       conv_run_o,
  output wire       conv_clk_o,
  // shared pins
  output wire [3:0] analog_pin_en_o,
  // interrupt
  input  wire       stack_full_i,
  output wire       irq_o
);

  // ========================================================================
  // states
  // ========================================================================
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_ARMED = 3'b010;
  localparam [2:0] ST_CONV  = 3'b100;

  localparam [6:0] CONV_LEN = (RES9 != 0) ? `ADCS_LEN_9BIT : `ADCS_LEN_8BIT;

  // ========================================================================
  // register address match
  // ========================================================================
  function adcs_hit;
    input [2:0] addr;
    input [2:0] off;
    begin
      adcs_hit = (addr == off);
    end
  endfunction

  // ========================================================================
  // pin selection decode
  // ========================================================================
  function [3:0] adcs_pin_map;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    adcs_pin_map = 4'h0;
        3'h1:    adcs_pin_map = 4'h1;
        3'h2:    adcs_pin_map = 4'h3;
        3'h3:    adcs_pin_map = 4'h7;
        default: adcs_pin_map = 4'hF;
      endcase
    end
  endfunction

  // ========================================================================
  // declarations
  // ========================================================================
  reg        start_q;
  reg        start_d;
  reg  [2:0] pin_sel_q;
  reg  [2:0] pin_sel_d;
  reg  [2:0] chan_q;
  reg  [2:0] chan_d;
  reg  [1:0] div_sel_q;
  reg  [1:0] div_sel_d;
  reg        pend_q;
  reg        pend_d;
  reg  [7:0] res_lo_q;
  reg  [7:0] res_lo_d;
  reg  [7:0] res_hi_q;
  reg  [7:0] res_hi_d;
  reg        irq_flag_q;
  reg        irq_flag_d;
  reg        irq_en_q;
  reg        irq_en_d;
  reg        gie_q;
  reg        gie_d;
  reg  [2:0] state_q;
  reg  [2:0] state_d;
  reg  [6:0] cnt_q;
  reg  [6:0] cnt_d;
  reg  [3:0] pin_en_q;
  reg  [7:0] rdata_q;
  reg  [7:0] rdata_d;
  reg        done;

  wire       wr_ctrl;
  wire       wr_clk;
  wire       wr_stat;
  wire       wr_mask;
  wire       powered;
  wire       tick;

  // ========================================================================
  // write decode
  // ========================================================================
  assign wr_ctrl = we_i && adcs_hit(addr_i, `ADCS_OFF_CTRL);
  assign wr_clk  = we_i && adcs_hit(addr_i, `ADCS_OFF_CLKSEL);
  assign wr_stat = we_i && adcs_hit(addr_i, `ADCS_OFF_IRQ_STAT);
  assign wr_mask = we_i && adcs_hit(addr_i, `ADCS_OFF_IRQ_MASK);

  // setup is register driven; only resolution is strapped by RES9
  always @* begin
    start_d   = start_q;
    pin_sel_d = pin_sel_q;
    chan_d    = chan_q;
    div_sel_d = div_sel_q;
    irq_en_d  = irq_en_q;
    gie_d     = gie_q;
    if (wr_ctrl) begin
      // channel and pins taken in one write
      start_d   = wdata_i[`ADCS_CTRL_START];
      pin_sel_d = wdata_i[`ADCS_CTRL_PIN_HI:`ADCS_CTRL_PIN_LO];
      chan_d    = wdata_i[`ADCS_CTRL_CH_HI:`ADCS_CTRL_CH_LO];
    end
    if (wr_clk) begin
      div_sel_d = wdata_i[`ADCS_CLK_SEL_HI:`ADCS_CLK_SEL_LO];
    end
    if (wr_mask) begin
      irq_en_d = wdata_i[`ADCS_IRQ_DONE];
      gie_d    = wdata_i[`ADCS_MASK_GIE];
    end
  end

  // ========================================================================
  // converter clock
  // ========================================================================
  adcs_clk_div u_clk_div (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .sel_i      (div_sel_q),
    .clr_i      (state_q != ST_CONV),
    .tick_o     (tick),
    .conv_clk_o (conv_clk_o)
  );

  // ========================================================================
  // sequencer
  // ========================================================================
  assign powered = |adcs_pin_map(pin_sel_q);

  always @* begin
    state_d = state_q;
    cnt_d   = cnt_q;
    done    = 1'b0;
    case (state_q)
      ST_IDLE: begin
        cnt_d = 7'd0;
        if (start_q) begin
          state_d = ST_ARMED;
        end
      end
      ST_ARMED: begin
        // converter held in reset while start stays high
        cnt_d = 7'd0;
        if (!start_q) begin
          state_d = ST_CONV;
        end
      end
      ST_CONV: begin
        if (start_q) begin
          state_d = ST_ARMED;
          cnt_d   = 7'd0;
        end else if (tick) begin
          if (cnt_q == CONV_LEN - 7'd1) begin
            state_d = ST_IDLE;
            cnt_d   = 7'd0;
            done    = 1'b1;
          end else begin
            cnt_d = cnt_q + 7'd1;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d   = 7'd0;
      end
    endcase
    // no pins selected: converter off, a start pulse is needed to recover
    if (!powered && !start_q) begin
      state_d = ST_IDLE;
      cnt_d   = 7'd0;
      done    = 1'b0;
    end
  end

  // ========================================================================
  // pending flag, results, interrupt flag
  // ========================================================================
  always @* begin
    pend_d     = pend_q;
    res_lo_d   = res_lo_q;
    res_hi_d   = res_hi_q;
    irq_flag_d = irq_flag_q;
    // selection change without a pulse leaves the flag untouched
    if (start_q) begin
      pend_d = 1'b1;
    end else if (done) begin
      pend_d = 1'b0;
    end
    if (done) begin
      if (RES9 != 0) begin
        res_hi_d = conv_data_i[8:1];
        res_lo_d = {conv_data_i[0], 7'h00};
      end else begin
        res_hi_d = 8'h00;
        res_lo_d = conv_data_i[7:0];
      end
    end
    // completion set beats a one-written clear in the same cycle
    if (wr_stat && wdata_i[`ADCS_IRQ_DONE]) begin
      irq_flag_d = 1'b0;
    end
    if (done) begin
      irq_flag_d = 1'b1;
    end
  end

  // ========================================================================
  // read port
  // ========================================================================
  always @* begin
    rdata_d = 8'h00;
    if (re_i) begin
      case (addr_i)
        `ADCS_OFF_CTRL:     rdata_d = {start_q, pend_q, pin_sel_q, chan_q};
        `ADCS_OFF_CLKSEL:   rdata_d = {6'h00, div_sel_q};
        `ADCS_OFF_RES_LO:   rdata_d = res_lo_q;
        `ADCS_OFF_RES_HI:   rdata_d = res_hi_q;
        `ADCS_OFF_IRQ_STAT: rdata_d = {7'h00, irq_flag_q};
        `ADCS_OFF_IRQ_MASK: rdata_d = {gie_q, 6'h00, irq_en_q};
        default:            rdata_d = 8'h00;
      endcase
    end
  end

  // ========================================================================
  // control registers
  // ========================================================================
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_q    <= 1'b0;
      pin_sel_q  <= `ADCS_RST_PIN_SEL;
      chan_q     <= `ADCS_RST_CHAN;
      pin_en_q   <= 4'h0;
    end else begin
      start_q    <= start_d;
      pin_sel_q  <= pin_sel_d;
      chan_q     <= chan_d;
      pin_en_q   <= adcs_pin_map(pin_sel_d);
    end
  end

  // ========================================================================
  // clock select and interrupt enables
  // ========================================================================
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_sel_q  <= `ADCS_RST_CLK_SEL;
      irq_en_q   <= 1'b0;
      gie_q      <= 1'b0;
    end else begin
      div_sel_q  <= div_sel_d;
      irq_en_q   <= irq_en_d;
      gie_q      <= gie_d;
    end
  end

  // ========================================================================
  // sequencer state
  // ========================================================================
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q    <= ST_IDLE;
      cnt_q      <= 7'd0;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
    end
  end

  // ========================================================================
  // flags, results and read data
  // ========================================================================
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_q     <= `ADCS_RST_PEND;
      res_lo_q   <= `ADCS_RST_RES;
      res_hi_q   <= `ADCS_RST_RES;
      irq_flag_q <= 1'b0;
      rdata_q    <= 8'h00;
    end else begin
      pend_q     <= pend_d;
      res_lo_q   <= res_lo_d;
      res_hi_q   <= res_hi_d;
      irq_flag_q <= irq_flag_d;
      rdata_q    <= rdata_d;
    end
  end

  // ========================================================================
  // outputs
  // ========================================================================
  assign rdata_o         = rdata_q;
  assign channel_o       = chan_q;
  assign conv_power_o    = powered;
  assign conv_reset_o    = (state_q != ST_CONV);
  assign conv_run_o      = (state_q == ST_CONV);
  assign analog_pin_en_o = pin_en_q;
  assign irq_o           = irq_flag_q && irq_en_q && gie_q && !stack_full_i;

endmodule // adcs_sequencer

//--- dv/adcs_conv_model.sv
// ==========================================
// converter core stand-in
// ==========================================
module adcs_conv_model (
  // clock
  input  wire logic       clk_i,
  // converter side
  input  wire logic [2:0] channel_i,
  input  wire logic       power_i,
  output logic      [8:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] junk_q = 9'h155;
  // an unpowered converter has no defined result
  always @(posedge clk_i) junk_q <= ~junk_q;
  assign data_o = power_i ? {channel_i, 6'h2D} : junk_q;
endmodule // adcs_conv_model

//--- dv/adcs_seq_props.sv
`include "adcs_map.vh"
// ==========================================
// port checker
// ==========================================
module adcs_seq_props #(
  parameter RES9 = 1
) (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       we_i,
  input wire logic       stack_full_i,
  input wire logic       conv_reset_o,
  input wire logic       conv_run_o,
  input wire logic       conv_clk_o,
  input wire logic       conv_power_o,
  input wire logic [3:0] analog_pin_en_o,
  input wire logic       irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [1:0]  div_q;
  logic        start_q;
  logic [2:0]  hist_q;
  logic [12:0] cnt_q;
  wire         ctrl_wr = we_i && addr_i == `ADCS_OFF_CTRL;
  wire  [12:0] len = (RES9 ? 13'd76 : 13'd64) << (div_q == 2'h0 ? 1 : div_q == 2'h1 ? 3 : 5);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q   <= 2'h0;
      start_q <= 1'b0;
      hist_q  <= 3'h0;
      cnt_q   <= 13'h0;
    end else begin
      if (we_i && addr_i == `ADCS_OFF_CLKSEL) div_q <= wdata_i[1:0];
      if (ctrl_wr) start_q <= wdata_i[7];
      hist_q <= {hist_q[1:0], ctrl_wr};
      cnt_q  <= conv_run_o ? cnt_q + 13'h1 : 13'h0;
    end
  end
  sequence s_arm; ctrl_wr && wdata_i[7]; endsequence
  sequence s_fire; ctrl_wr && !wdata_i[7] && start_q && wdata_i[5:3] != 3'h0; endsequence
  property p_hold; s_arm |-> ##2 (conv_reset_o && !conv_run_o); endproperty
  a_hold: assert property (p_hold) else $error("start high did not hold reset");
  property p_launch; s_fire |-> ##[1:3] (conv_run_o && !conv_reset_o); endproperty
  a_launch: assert property (p_launch) else $error("start fall did not launch");
  property p_excl; conv_run_o |-> !conv_reset_o; endproperty
  a_excl: assert property (p_excl) else $error("run and reset together");
  property p_clk_idle; !conv_run_o [*2] |-> !conv_clk_o; endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("converter clock while idle");
  property p_none; ctrl_wr && wdata_i[5:3] == 3'h0 |=> analog_pin_en_o == 4'h0 && !conv_power_o;
  endproperty
  a_none: assert property (p_none) else $error("zero selection left pins or power");
  property p_all; ctrl_wr && wdata_i[5] |=> analog_pin_en_o == 4'hF && conv_power_o; endproperty
  a_all: assert property (p_all) else $error("high selection not all pins");
  property p_irq_stack; stack_full_i |-> !irq_o; endproperty
  a_irq_stack: assert property (p_irq_stack) else $error("irq with full stack");
  property p_irq_cause; $rose(irq_o) |-> $fell(conv_run_o) || $fell(stack_full_i) || $past(we_i);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
  property p_len; $fell(conv_run_o) && hist_q == 3'h0 |-> $past(cnt_q) + 13'd4 >= len
    && $past(cnt_q) <= len + 13'd4; endproperty
  a_len: assert property (p_len) else $error("conversion length wrong");
  property p_len_max; conv_run_o |-> cnt_q <= len + 13'd4; endproperty
  a_len_max: assert property (p_len_max) else $error("conversion overran");
endmodule // adcs_seq_props
bind adcs_sequencer adcs_seq_props #(.RES9(RES9)) u_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .stack_full_i(stack_full_i),
  .conv_reset_o(conv_reset_o), .conv_run_o(conv_run_o), .conv_clk_o(conv_clk_o),
  .conv_power_o(conv_power_o), .analog_pin_en_o(analog_pin_en_o), .irq_o(irq_o));

//--- dv/tb_adcs_sequencer.sv
// ==========================================
// testbench
// ==========================================
module tb_adcs_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_i = 1'b0, rst_n_i = 1'b0, we_i = 1'b0, re_i = 1'b0, stack_full_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  wire  [7:0] rdata_o;
  wire  [8:0] data;
  wire  [2:0] chan;
  wire  [3:0] pins;
  wire        power, creset, run, irq_o;
  int         error_cnt = 0, total_checks = 0, n;
  int         divs [4] = '{2, 8, 32, 32};
  adcs_sequencer u_adcs_sequencer (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .conv_data_i(data),
    .channel_o(chan), .conv_power_o(power), .conv_reset_o(creset), .conv_run_o(run),
    .conv_clk_o(), .analog_pin_en_o(pins), .stack_full_i(stack_full_i), .irq_o(irq_o));
  adcs_conv_model u_adcs_conv_model (.clk_i(clk_i), .channel_i(chan), .power_i(power),
    .data_o(data));
  initial forever #5 clk_i = ~clk_i;
  task check(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a; wdata_i <= d; we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a; re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1 check({1'b0, rdata_o}, {1'b0, e});
  endtask
  task conv(input logic [7:0] ctl, input int cyc);
    logic [8:0] d;
    d = {ctl[2:0], 6'h2D};
    wr(3'h4, 8'h01);
    wr(3'h0, ctl | 8'h80);
    rd(3'h0, ctl | 8'hC0);
    check(creset, 1'b1);
    wr(3'h0, ctl);
    n = 0;
    while (irq_o !== 1'b1 && n < 9000) begin
      @(posedge clk_i);
      #1 n++;
      if (n == 50) check(run, 1'b1);
    end
    check(n >= cyc - 2 && n <= cyc + 6, 1'b1);
    rd(3'h0, ctl);
    rd(3'h3, d[8:1]);
    rd(3'h2, {d[0], 7'h00});
    rd(3'h4, 8'h01);
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(3'h0, 8'h40);
    rd(3'h1, 8'h00);
    wr(3'h6, 8'hFF);
    rd(3'h6, 8'h00);
    wr(3'h0, 8'h0A);
    #1 check({chan, pins, power}, {3'h2, 4'h1, 1'b1});
    wr(3'h5, 8'h81);
    conv(8'h0A, 76 * 2);
    @(posedge clk_i);
    stack_full_i <= 1'b1;
    @(posedge clk_i);
    #1 check(irq_o, 1'b0);
    @(posedge clk_i);
    stack_full_i <= 1'b0;
    wr(3'h5, 8'h01);
    #1 check(irq_o, 1'b0);
    wr(3'h5, 8'h81);
    #1 check(irq_o, 1'b1);
    for (int i = 1; i < 4; i++) begin
      wr(3'h1, i[7:0]);
      conv(8'h23, 76 * divs[i]);
      check(pins, 4'hF);
    end
    wr(3'h0, 8'h13);
    rd(3'h0, 8'h13);
    wr(3'h4, 8'h01);
    wr(3'h0, 8'hA3);
    wr(3'h0, 8'h23);
    repeat (20) @(posedge clk_i);
    wr(3'h0, 8'hA3);
    repeat (2) @(posedge clk_i);
    #1 check({run, creset}, 2'b01);
    wr(3'h0, 8'h23);
    repeat (20) @(posedge clk_i);
    wr(3'h0, 8'h00);
    repeat (2) @(posedge clk_i);
    #1 check({pins, power, run, irq_o}, 7'h00);
    report_and_stop();
  end
endmodule // tb_adcs_sequencer
